// ### wtb_cfg.svh
/*
 * wtb_cfg.svh: offsets, fixed top values and reset values of the wide timer.
 * Assumes inclusion by bare name from wtb_timer.sv; wtb_pkg.sv does not include it.
 */
`ifndef WTB_CFG_SVH
`define WTB_CFG_SVH

// byte addresses on the 8-bit port, low byte even, high byte odd
`define WTB_ADDR_CNT_LO   4'h0
`define WTB_ADDR_CNT_HI   4'h1
`define WTB_ADDR_CMPA_LO  4'h2
`define WTB_ADDR_CMPA_HI  4'h3
`define WTB_ADDR_CMPB_LO  4'h4
`define WTB_ADDR_CMPB_HI  4'h5
`define WTB_ADDR_CMPC_LO  4'h6
`define WTB_ADDR_CMPC_HI  4'h7
`define WTB_ADDR_CAP_LO   4'h8
`define WTB_ADDR_CAP_HI   4'h9

// limit values of the count sequence
`define WTB_BOTTOM        16'h0000
`define WTB_MAX           16'hffff
`define WTB_TOP_8BIT      16'h00ff
`define WTB_TOP_9BIT      16'h01ff
`define WTB_TOP_10BIT     16'h03ff

// reset values
`define WTB_RST_WORD      16'h0000
`define WTB_RST_HOLD      8'h00

// noise filter length in core clocks
`define WTB_FILT_LEN      4

`endif

// ### wtb_pkg.sv
/*
 * wtb_pkg.sv: types shared by the wide timer and its testbench.
 * Assumes wtb_cfg.svh is on the include path.
 */
package wtb_pkg;

	// source of the top of the count sequence
	typedef enum logic [2:0] {
		WTB_TOP_FIX8  = 3'h0,
		WTB_TOP_FIX9  = 3'h1,
		WTB_TOP_FIX10 = 3'h2,
		WTB_TOP_CMPA  = 3'h3,
		WTB_TOP_CAP   = 3'h4,
		WTB_TOP_MAX   = 3'h5
	} wtb_top_sel_t;

	// mode controls, held by the surrounding control logic
	typedef struct packed {
		logic         run;         // count enable
		logic         pwm;         // pwm waveform on compare pins
		wtb_top_sel_t top_sel;     // where top comes from
		logic         cap_rising;  // capture on rising edge
		logic         cap_from_cmp;// event from analog comparator
		logic         filt_en;     // noise filter on
	} wtb_mode_t;

	// cpu byte access
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} wtb_bus_t;

endpackage

// ### wtb_timer.sv
/*
 * wtb_timer.sv: 16-bit timer with shared high-byte holding register,
 * three compare channels, capture with noise filter and limit detection.
 * Assumes a core that makes single-cycle byte accesses on an 8-bit port,
 * synchronous inputs and mode bits driven by the surrounding control logic.
 */
`timescale 1ns/1ns
`include "wtb_cfg.svh"

// Contract
// R1: each compare match drives the waveform output on its pin.
// R2: a compare match sets that channel's sticky match flag.
// R3: a selected edge from pin or comparator copies the count into capture; the code takes no stamp while capture is the top source.
// R4: a digital noise filter guards the capture event input.
// R5: top is 0x00ff, 0x01ff, 0x03ff, compare a or capture, by mode.
// R6: with compare a as pwm top, channel a gives no pwm output.
// R7: compare a as top is double buffered, updated at the bottom; the code also takes it up at once while the count is stopped.
// R8: bottom is signalled when the count becomes 0x0000.
// R9: max is signalled at 0xffff, apart from the mode top.
// R10: one shared 8-bit high-byte holding register serves all five words.
// R11: a low-byte write loads held high byte and low byte together.
// R12: a low-byte read copies that word's high byte into the holding register; the code does so for count and capture only, compare low reads leave it.
// R13: compare high-byte reads come direct and leave the holding register alone.
// R14: software writes high byte first and reads low byte first.
// R15: main code masks interrupts around a two-byte access.
// R16: one high-byte write may serve several low-byte writes.
// R17: a cpu write to the count beats clear or count.
// R18: holding register resets to zero and holds until loaded.
module wtb_timer #(
	parameter int FILT_LEN = `WTB_FILT_LEN
) (
	input  wire logic              i_core_clk,      // 10 mhz core clock
	input  wire logic              i_rst_n,         // async reset, low active
	input  wire wtb_pkg::wtb_mode_t i_mode,         // mode controls
	input  wire wtb_pkg::wtb_bus_t i_bus,           // cpu byte access
	input  wire logic              i_flag_clr_a,    // clear match flag a
	input  wire logic              i_flag_clr_b,    // clear match flag b
	input  wire logic              i_flag_clr_c,    // clear match flag c
	input  wire logic              i_flag_clr_cap,  // clear capture flag
	input  wire logic              i_event_input_pin, // capture pin
	input  wire logic              i_comp_out,      // analog comparator out
	output logic [7:0]             o_rdata,         // read data
	output logic [15:0]            o_count_value,   // counter
	output logic [2:0]             o_match_flags,   // sticky match flags
	output logic                   o_cap_flag,      // sticky capture flag
	output logic [2:0]             o_wave_output_pins, // compare outputs
	output logic                   o_at_bottom,     // count is bottom
	output logic                   o_at_max,        // count is max
	output logic                   o_at_top         // count is top
);

	// the shift window needs two taps, and the settle counter is five bits wide
	if (FILT_LEN < 2 || FILT_LEN > 16) begin : g_filt_len_check
		$error("FILT_LEN out of range");
	end

	logic [15:0] count_value;
	logic [15:0] compare_value [3];   // active compare values a, b, c
	logic [15:0] cmpa_buf;             // buffered compare a for top use
	logic [15:0] captured_value;
	logic [7:0]  hold_hi;
	logic [15:0] top_val;
	logic [15:0] next_count;
	logic [15:0] wr_word;
	logic        wr_lo;
	logic        rd_lo;
	logic [2:0]  match;
	logic        ev_raw;
	logic [FILT_LEN-1:0] filt_sh;
	logic        ev_clean;
	logic        ev_prev;
	logic        cap_edge;
	logic        cmpa_is_top;
	logic        cap_take;
	logic [4:0]  settle_cnt;
	logic        ev_armed;

	// byte port decode; the low byte of a word triggers every 16-bit move
	assign wr_word     = {hold_hi, i_bus.wdata};
	assign wr_lo       = i_bus.wr && !i_bus.addr[0];
	assign rd_lo       = i_bus.rd && !i_bus.addr[0];
	assign cmpa_is_top = (i_mode.top_sel == wtb_pkg::WTB_TOP_CMPA);

	// top selection by mode
	// codes 6 and 7 are unused and fall back to the full 16-bit range
	// R5: top source mux
	always_comb begin
		unique case (i_mode.top_sel)
			wtb_pkg::WTB_TOP_FIX8:  top_val = `WTB_TOP_8BIT;
			wtb_pkg::WTB_TOP_FIX9:  top_val = `WTB_TOP_9BIT;
			wtb_pkg::WTB_TOP_FIX10: top_val = `WTB_TOP_10BIT;
			wtb_pkg::WTB_TOP_CMPA:  top_val = compare_value[0];
			wtb_pkg::WTB_TOP_CAP:   top_val = captured_value;
			default:                top_val = `WTB_MAX;
		endcase
	end

	// limit detection, all combinational on the live count
	// levels, not pulses: they keep showing while the count is stopped
	// R8: bottom detect
	assign o_at_bottom = (count_value == `WTB_BOTTOM);
	// R9: max detect
	assign o_at_max    = (count_value == `WTB_MAX);
	assign o_at_top    = (count_value == top_val);

	// counting wraps at top back to bottom
	// a count above top, after a cpu write, runs on to max and wraps there
	always_comb begin
		next_count = count_value;
		if (i_mode.run) begin
			next_count = o_at_top ? `WTB_BOTTOM : count_value + 16'h0001;
		end
	end

	// counter; cpu write wins over counting
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count_value <= `WTB_RST_WORD;
		// R17: cpu write priority
		end else if (wr_lo && i_bus.addr == `WTB_ADDR_CNT_LO) begin
			// R11: atomic word load
			count_value <= wr_word;
		end else begin
			count_value <= next_count;
		end
	end

	// holding register: cpu high-byte writes and count or capture low-byte reads load it
	// any odd-address write loads it, even an unmapped one, to keep the decode small
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			// R18: reset to zero
			hold_hi <= `WTB_RST_HOLD;
		end else if (i_bus.wr && i_bus.addr[0]) begin
			// R10: shared high byte
			hold_hi <= i_bus.wdata;
		end else if (rd_lo) begin
			// R12: latch high on low read
			unique case (i_bus.addr)
				`WTB_ADDR_CNT_LO: hold_hi <= count_value[15:8];
				`WTB_ADDR_CAP_LO: hold_hi <= captured_value[15:8];
				// R13: compare reads bypass
				default:          hold_hi <= hold_hi;
			endcase
		end
	end

	// compare a buffer: written any time, taken up at bottom, or at once while stopped, when it is top
	// a write while a is top lands here only, so the period never jumps mid-cycle
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cmpa_buf <= `WTB_RST_WORD;
		end else if (wr_lo && i_bus.addr == `WTB_ADDR_CMPA_LO) begin
			cmpa_buf <= wr_word;
		end
	end

	// compare registers; a is double buffered while serving as top
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : g_cmp
			localparam logic [3:0] LO_ADDR = 4'(`WTB_ADDR_CMPA_LO + 2 * g);
			always_ff @(posedge i_core_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					compare_value[g] <= `WTB_RST_WORD;
				end else if (g == 0 && cmpa_is_top) begin
					// R7: update top at bottom, or at once while stopped
					if (o_at_bottom || !i_mode.run) begin
						compare_value[g] <= cmpa_buf;
					end
				end else if (wr_lo && i_bus.addr == LO_ADDR) begin
					compare_value[g] <= wr_word;
				end
			end
			assign match[g] = (count_value == compare_value[g]);

			// sticky flag, a new match beats a clear
			// only a match while counting sets it; software can only clear it
			always_ff @(posedge i_core_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					o_match_flags[g] <= 1'b0;
				// R2: set match flag
				end else if (match[g] && i_mode.run) begin
					o_match_flags[g] <= 1'b1;
				end else if ((g == 0 && i_flag_clr_a) || (g == 1 && i_flag_clr_b)
					|| (g == 2 && i_flag_clr_c)) begin
					o_match_flags[g] <= 1'b0;
				end
			end

			// set at bottom, cleared on match: simple single-slope pwm
			always_ff @(posedge i_core_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					o_wave_output_pins[g] <= 1'b0;
				// R6: no pwm when a is top
				end else if (g == 0 && cmpa_is_top && i_mode.pwm) begin
					o_wave_output_pins[g] <= 1'b0;
				// R1: match drives waveform
				end else if (i_mode.pwm) begin
					if (match[g]) begin
						o_wave_output_pins[g] <= 1'b0;
					end else if (o_at_bottom) begin
						o_wave_output_pins[g] <= 1'b1;
					end
				end else if (match[g] && i_mode.run) begin
					o_wave_output_pins[g] <= !o_wave_output_pins[g];
				end
			end
		end
	endgenerate

	// event source and noise filter: level must agree for FILT_LEN clocks
	// trade-off: every filtered capture lands FILT_LEN clocks later than an unfiltered one
	assign ev_raw = i_mode.cap_from_cmp ? i_comp_out : i_event_input_pin;
	// R4: noise filter
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			filt_sh  <= '0;
			ev_clean <= 1'b0;
		end else begin
			filt_sh <= {filt_sh[FILT_LEN-2:0], ev_raw};
			if (!i_mode.filt_en) begin
				ev_clean <= ev_raw;
			end else if (&filt_sh) begin
				ev_clean <= 1'b1;
			end else if (~|filt_sh) begin
				ev_clean <= 1'b0;
			end
		end
	end

	// edge detect on the cleaned event
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ev_prev <= 1'b0;
		end else begin
			ev_prev <= ev_clean;
		end
	end
	assign cap_edge = ev_armed
		&& (i_mode.cap_rising ? (ev_clean && !ev_prev) : (!ev_clean && ev_prev));

	// edge detect stays masked until the filter has followed the pin once,
	// so a pin that idles high cannot fake a capture right after reset
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			settle_cnt <= 5'h00;
		end else if (!ev_armed) begin
			settle_cnt <= settle_cnt + 5'h01;
		end
	end
	assign ev_armed = (settle_cnt == 5'(FILT_LEN + 2));

	// no stamp while capture is the top source, or the period would move
	assign cap_take = cap_edge && (i_mode.top_sel != wtb_pkg::WTB_TOP_CAP);

	// capture register: edge stamps count, cpu low write loads it
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			captured_value <= `WTB_RST_WORD;
		// R3: capture on edge
		end else if (cap_take) begin
			captured_value <= count_value;
		end else if (wr_lo && i_bus.addr == `WTB_ADDR_CAP_LO) begin
			captured_value <= wr_word;
		end
	end

	// capture flag, set beats clear
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_cap_flag <= 1'b0;
		end else if (cap_take) begin
			o_cap_flag <= 1'b1;
		end else if (i_flag_clr_cap) begin
			o_cap_flag <= 1'b0;
		end
	end

	// read data registered, valid the cycle after the read strobe
	// high bytes of count and capture come from the holding register: one snapshot
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= 8'h00;
		end else if (i_bus.rd) begin
			unique case (i_bus.addr)
				`WTB_ADDR_CNT_LO:  o_rdata <= count_value[7:0];
				`WTB_ADDR_CMPA_LO: o_rdata <= compare_value[0][7:0];
				`WTB_ADDR_CMPA_HI: o_rdata <= compare_value[0][15:8];
				`WTB_ADDR_CMPB_LO: o_rdata <= compare_value[1][7:0];
				`WTB_ADDR_CMPB_HI: o_rdata <= compare_value[1][15:8];
				`WTB_ADDR_CMPC_LO: o_rdata <= compare_value[2][7:0];
				`WTB_ADDR_CMPC_HI: o_rdata <= compare_value[2][15:8];
				`WTB_ADDR_CAP_LO:  o_rdata <= captured_value[7:0];
				`WTB_ADDR_CNT_HI,
				`WTB_ADDR_CAP_HI:  o_rdata <= hold_hi;
				default:           o_rdata <= 8'h00;
			endcase
		end
	end

	assign o_count_value = count_value;

endmodule

// ### wtb_timer_sva.sv
/* wtb_timer_sva.sv: port checks of the wide timer.
   Assumes binding to wtb_timer, one clock domain. */
`timescale 1ns/1ns
module wtb_timer_chk #(
	parameter int FILT_LEN = 4
) (
	input wire logic               i_core_clk,         // clock
	input wire logic               i_rst_n,            // reset
	input wire wtb_pkg::wtb_mode_t i_mode,             // mode
	input wire wtb_pkg::wtb_bus_t  i_bus,              // cpu port
	input wire logic               i_flag_clr_a,       // clear a
	input wire logic [7:0]         o_rdata,            // read data
	input wire logic [15:0]        o_count_value,      // count
	input wire logic [2:0]         o_match_flags,      // flags
	input wire logic [2:0]         o_wave_output_pins, // pins
	input wire logic               o_at_bottom,        // bottom
	input wire logic               o_at_max,           // max
	input wire logic               o_at_top            // top
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	// byte cycles on the cpu port
	sequence s_wr(a); i_bus.wr && i_bus.addr == a; endsequence
	sequence s_rd(a); i_bus.rd && !i_bus.wr && i_bus.addr == a; endsequence
	property p_bottom; o_at_bottom == (o_count_value == 16'h0000); endproperty
	a_bottom: assert property (p_bottom) else $error("bottom flag wrong");
	property p_max; o_at_max == (o_count_value == 16'hffff); endproperty
	a_max: assert property (p_max) else $error("max flag wrong");
	property p_top;
		i_mode.top_sel == wtb_pkg::WTB_TOP_FIX9 |-> o_at_top == (o_count_value == 16'h01ff);
	endproperty
	a_top: assert property (p_top) else $error("top flag wrong");
	// both bytes land together, cpu write beats counting
	property p_cnt_wr;
		s_wr(4'h1) ##1 s_wr(4'h0) |=> o_count_value == {$past(i_bus.wdata, 2), $past(i_bus.wdata)};
	endproperty
	a_cnt_wr: assert property (p_cnt_wr) else $error("count write not atomic");
	// compare reads in between must not disturb the held byte
	property p_hold_kept;
		s_rd(4'h0) ##1 s_rd(4'h5) ##1 s_rd(4'h1) |=> o_rdata == $past(o_count_value[15:8], 3);
	endproperty
	a_hold_kept: assert property (p_hold_kept) else $error("held byte lost");
	property p_cmp_hi;
		s_wr(4'h5) ##1 s_wr(4'h4) ##1 s_rd(4'h5) |=> o_rdata == $past(i_bus.wdata, 3);
	endproperty
	a_cmp_hi: assert property (p_cmp_hi) else $error("compare high read wrong");
	property p_pwm_a;
		(i_mode.pwm && i_mode.top_sel == wtb_pkg::WTB_TOP_CMPA) [*2] |-> !o_wave_output_pins[0];
	endproperty
	a_pwm_a: assert property (p_pwm_a) else $error("channel a pwm active");
	property p_flag_hold; o_match_flags[0] && !i_flag_clr_a |=> o_match_flags[0]; endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("match flag dropped");
endmodule

bind wtb_timer wtb_timer_chk #(.FILT_LEN(FILT_LEN)) u_wtb_timer_chk (.i_core_clk(i_core_clk),
	.i_rst_n(i_rst_n), .i_mode(i_mode), .i_bus(i_bus), .i_flag_clr_a(i_flag_clr_a),
	.o_rdata(o_rdata), .o_count_value(o_count_value), .o_match_flags(o_match_flags),
	.o_wave_output_pins(o_wave_output_pins), .o_at_bottom(o_at_bottom),
	.o_at_max(o_at_max), .o_at_top(o_at_top));

// ### wtb_cpu_model.sv
/* wtb_cpu_model.sv: core making byte accesses on the timer port.
   Assumes calls start at a falling clock edge. */
`timescale 1ns/1ns
module wtb_cpu_model (
	input  wire logic         i_core_clk, // clock
	input  wire logic [7:0]   i_rdata,    // read data
	output wtb_pkg::wtb_bus_t o_bus       // byte access
);
	// idle port, data scrambled so a stale byte never passes
	initial o_bus = '0;
	task automatic idle();
		o_bus.wr = 1'b0;
		o_bus.rd = 1'b0;
		o_bus.wdata = ~o_bus.wdata;
		@(negedge i_core_clk);
	endtask
	// one byte, taken at the next rising edge
	task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d,
		output logic [7:0] q);
		o_bus.wr = w;
		o_bus.rd = !w;
		o_bus.addr = a;
		o_bus.wdata = d;
		@(negedge i_core_clk);
		q = i_rdata;
	endtask
	task automatic write16(input logic [3:0] a, input logic [15:0] v);
		logic [7:0] q;
		acc(1'b1, a | 4'h1, v[15:8], q);
		acc(1'b1, a, v[7:0], q);
		idle();
	endtask
	task automatic read16(input logic [3:0] a, output logic [15:0] v);
		acc(1'b0, a, 8'h00, v[7:0]);
		acc(1'b0, a | 4'h1, 8'h00, v[15:8]);
		idle();
	endtask
endmodule

// ### wtb_timer_test.sv
/* wtb_timer_test.sv: self-checking bench of the wide timer.
   Assumes wtb_cpu_model drives the byte port. */
`timescale 1ns/1ns
module wtb_timer_test;
	logic               clk = 1'b0;
	logic               rst_n = 1'b0;
	wtb_pkg::wtb_mode_t mode = '0;
	wtb_pkg::wtb_bus_t  bus;
	logic [3:0]         clr = '0;
	logic               ev = 1'b0;
	logic [7:0]         rdata, q;
	logic [15:0]        cnt, v, r;
	logic [2:0]         flg, wave;
	logic               capf, bot, mx, top, w0;
	int                 n_mismatch = 0;
	int                 n_tests = 0;
	int                 seed = 32'h8ff8;

	// clock, event routed to the selected source only
	always #50 clk = ~clk;
	wtb_timer #(.FILT_LEN(4)) u_wtb_timer (.i_core_clk(clk), .i_rst_n(rst_n), .i_mode(mode),
		.i_bus(bus), .i_flag_clr_a(clr[0]), .i_flag_clr_b(clr[1]), .i_flag_clr_c(clr[2]),
		.i_flag_clr_cap(clr[3]), .i_event_input_pin(ev & !mode.cap_from_cmp),
		.i_comp_out(ev & mode.cap_from_cmp), .o_rdata(rdata), .o_count_value(cnt),
		.o_match_flags(flg), .o_cap_flag(capf), .o_wave_output_pins(wave),
		.o_at_bottom(bot), .o_at_max(mx), .o_at_top(top));
	wtb_cpu_model u_wtb_cpu_model (.i_core_clk(clk), .i_rdata(rdata), .o_bus(bus));

	function automatic logic [15:0] top_of(int s);
		return s == 0 ? 16'h00ff : s == 1 ? 16'h01ff : s == 2 ? 16'h03ff : 16'hffff;
	endfunction
	task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic conclude();
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// watchdog: the run needs under a thousand cycles, allow twenty times that
	initial begin
		#(20000 * 100);
		n_mismatch++;
		conclude();
	end
	// main sequence
	initial begin
		tick(10);
		rst_n = 1'b1;
		check("bottom", bot, 1'b1);
		u_wtb_cpu_model.acc(1'b0, 4'h1, 8'h00, q);
		check("hold reset", q, 8'h00);
		for (int i = 0; i < 10; i++) begin
			v = 16'($random(seed));
			u_wtb_cpu_model.write16(4'(2 * (i % 5)), v);
			u_wtb_cpu_model.read16(4'(2 * (i % 5)), r);
			check("word", r, v);
		end
		for (int s = 0; s < 4; s++) begin
			mode.top_sel = s == 3 ? wtb_pkg::WTB_TOP_MAX : wtb_pkg::wtb_top_sel_t'(s);
			u_wtb_cpu_model.write16(4'h0, top_of(s));
			check("top", top, 1'b1);
			check("max", mx, s == 3);
		end
		mode.top_sel = wtb_pkg::WTB_TOP_CMPA;
		u_wtb_cpu_model.write16(4'h2, 16'h0040);
		u_wtb_cpu_model.write16(4'h0, 16'h0040);
		check("cmpa top", top, 1'b1);
		// one high byte serves two compare words
		v = 16'($random(seed));
		u_wtb_cpu_model.acc(1'b1, 4'h5, v[15:8], q);
		u_wtb_cpu_model.acc(1'b1, 4'h4, v[7:0], q);
		u_wtb_cpu_model.acc(1'b0, 4'h5, 8'h00, q);
		check("cmp high", q, v[15:8]);
		u_wtb_cpu_model.acc(1'b1, 4'h6, 8'h5a, q);
		u_wtb_cpu_model.idle();
		u_wtb_cpu_model.read16(4'h6, r);
		check("shared high", r, {v[15:8], 8'h5a});
		mode.top_sel = wtb_pkg::WTB_TOP_FIX8;
		mode.run = 1'b1;
		v = {8'h00, 7'($random(seed)), 1'b0};
		u_wtb_cpu_model.acc(1'b1, 4'h1, v[15:8], q);
		u_wtb_cpu_model.acc(1'b1, 4'h0, v[7:0], q);
		check("write wins", cnt, v);
		u_wtb_cpu_model.idle();
		check("count step", cnt, v + 16'h0001);
		mode.run = 1'b0;
		u_wtb_cpu_model.write16(4'h4, 16'h0020);
		u_wtb_cpu_model.write16(4'h0, 16'h0000);
		w0 = wave[1];
		clr[1] = 1'b1;
		tick(1);
		clr[1] = 1'b0;
		mode.run = 1'b1;
		tick(36);
		mode.run = 1'b0;
		check("match b", flg[1], 1'b1);
		check("pin b", wave[1], !w0);
		clr[1] = 1'b1;
		tick(1);
		clr[1] = 1'b0;
		check("clear b", flg[1], 1'b0);
		mode.pwm = 1'b1;
		mode.top_sel = wtb_pkg::WTB_TOP_CMPA;
		mode.run = 1'b1;
		tick(100);
		check("pwm a off", wave[0], 1'b0);
		// a new top written mid-period waits for the bottom
		u_wtb_cpu_model.write16(4'h2, 16'h0030);
		u_wtb_cpu_model.read16(4'h2, r);
		check("top held", r, 16'h0040);
		tick(70);
		u_wtb_cpu_model.read16(4'h2, r);
		check("top taken", r, 16'h0030);
		mode = '0;
		// capture register as top source
		mode.top_sel = wtb_pkg::WTB_TOP_CAP;
		v = 16'($random(seed));
		u_wtb_cpu_model.write16(4'h8, v);
		u_wtb_cpu_model.write16(4'h0, v);
		check("cap top", top, 1'b1);
		mode.top_sel = wtb_pkg::WTB_TOP_FIX8;
		mode.filt_en = 1'b1;
		// a rise from the pin, then a fall from the comparator;
		// a short spike is filtered, a steady edge captures
		for (int s = 0; s < 2; s++) begin
			mode.cap_from_cmp = s[0];
			mode.cap_rising = !s[0];
			ev = s[0];
			tick(10);
			v = 16'($random(seed));
			u_wtb_cpu_model.write16(4'h0, v);
			clr[3] = 1'b1;
			tick(1);
			clr[3] = 1'b0;
			ev = !s[0];
			tick(2);
			ev = s[0];
			tick(10);
			check("spike", capf, 1'b0);
			ev = !s[0];
			tick(12);
			check("capture flag", capf, 1'b1);
			u_wtb_cpu_model.read16(4'h8, r);
			check("captured", r, v);
			ev = s[0];
			tick(10);
		end
		u_wtb_cpu_model.acc(1'b0, 4'h0, 8'h00, q);
		u_wtb_cpu_model.acc(1'b0, 4'h5, 8'h00, q);
		u_wtb_cpu_model.acc(1'b0, 4'h1, 8'h00, q);
		u_wtb_cpu_model.idle();
		check("held high", q, v[15:8]);
		conclude();
	end
endmodule
